// ==== mbxirq_regs.svh ====
// Register offsets, field positions and reset values of the mailbox interrupt block.
// Assumes a 32-bit AHB-Lite slave with one aligned word per register.
// How it works
// (R01) Bit 4 enables mailbox 0 interrupt, reset 0
// (R02) Enabled mailbox raises interrupt on host write
// (R03) Bit 3 is mailbox 3 pending, reset 0
// (R04) Bit 2 is mailbox 2 pending, reset 0
// (R05) Bit 1 is mailbox 1 pending, reset 0
// (R06) Bit 0 is mailbox 0 pending, reset 0
// (R07) Local side reads/writes pending; host only reads
// (R08) Bit 5 enables mailbox 1 interrupt, reset 0
// (R09) Host write sets; write-one clears; OR output
`ifndef MBXIRQ_REGS_SVH
`define MBXIRQ_REGS_SVH
// Control and status word offset
`define MBXIRQ_CTRL_OFFSET   12'h000
// Field positions
`define MBXIRQ_PEND_LSB      0
`define MBXIRQ_PEND_MSB      3
`define MBXIRQ_EN0_BIT       4
`define MBXIRQ_EN1_BIT       5
// Reset values
`define MBXIRQ_PEND_RESET    4'h0
`define MBXIRQ_EN_RESET      2'h0
`define MBXIRQ_RDATA_RESET   32'h0000_0000
`endif

// ==== mbxirq_pkg.sv ====
// Types shared by the mailbox interrupt block.
// Assumes nothing beyond the register header.
package mbxirq_pkg;
    // Bus slave phase, Gray coded
    typedef enum logic [1:0] {
        MBXIRQ_IDLE = 2'h0,
        MBXIRQ_DATA = 2'h1
    } mbxirq_phase_t;
endpackage

// ==== mbxirq_top.sv ====
// Mailbox interrupt enable and pending flags behind an AHB-Lite slave.
// Assumes host mailbox-write strobes are one-cycle pulses synchronous to CLK.
`timescale 1ns/100ps
`include "mbxirq_regs.svh"
module mbxirq_top (
    input  wire logic        CLK,
    input  wire logic        RESET_N,
    input  wire logic        CLK_EN,
    input  wire logic        HSEL,
    input  wire logic [11:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic      [31:0] HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    input  wire logic [3:0]  HOST_MBOX_WR,
    output logic      [3:0]  HOST_PEND_VIEW,
    output logic             LOCAL_IRQ
);
    logic [3:0] pending;                 // Mailbox pending flags
    logic [1:0] irq_enable;              // Mailbox 0 and 1 enables
    mbxirq_pkg::mbxirq_phase_t phase;    // Data phase tracker
    logic       wr_pend;                 // Write data phase to control word
    logic       addr_hit;                // Address phase hits the word
    logic [3:0] clr_mask;                // Write-one-clear mask
    logic [3:0] next_pending;            // Next flag value
    logic       next_irq;                // Next interrupt level

    // Control word byte address; a macro literal cannot be part-selected, so keep a typed copy
    localparam logic [11:0] CTRL_OFF = `MBXIRQ_CTRL_OFFSET;

    // Decode an active transfer to the control word
    function automatic logic hits(input logic [11:0] a, input logic [1:0] t, input logic s);
        hits = s && t[1] && (a[11:2] == CTRL_OFF[11:2]);
    endfunction

    assign addr_hit = hits(HADDR, HTRANS, HSEL) && HREADY;

    // Address phase capture; always zero wait, always OKAY
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            wr_pend   <= 1'b0;
            phase     <= mbxirq_pkg::MBXIRQ_IDLE;
            HREADYOUT <= 1'b1;
            HRESP     <= 1'b0;
        end else if (CLK_EN) begin
            wr_pend <= addr_hit && HWRITE;
            phase   <= addr_hit ? mbxirq_pkg::MBXIRQ_DATA : mbxirq_pkg::MBXIRQ_IDLE;
            case (phase)
                mbxirq_pkg::MBXIRQ_IDLE: HREADYOUT <= 1'b1;
                mbxirq_pkg::MBXIRQ_DATA: HREADYOUT <= 1'b1;
                default:                 HREADYOUT <= 1'b1;
            endcase
        end
    end

    // Enables: local side read/write, cleared at reset
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            irq_enable <= `MBXIRQ_EN_RESET;                              // [R01] [R08]
        end else if (CLK_EN && wr_pend) begin
            irq_enable <= {HWDATA[`MBXIRQ_EN1_BIT], HWDATA[`MBXIRQ_EN0_BIT]}; // [R01] [R08]
        end
    end

    // Set wins over a clear in the same cycle, so no host write taken with clock enable high is lost
    always_comb begin
        clr_mask     = wr_pend ? HWDATA[`MBXIRQ_PEND_MSB:`MBXIRQ_PEND_LSB] : 4'h0; // [R07] [R09]
        next_pending = (pending & ~clr_mask) | HOST_MBOX_WR;                       // [R09]
        next_irq     = |(next_pending[1:0] & irq_enable);                          // [R02] [R09]
    end

    // Pending flags for mailboxes 0 to 3
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            pending <= `MBXIRQ_PEND_RESET;      // [R03] [R04] [R05] [R06]
        end else if (CLK_EN) begin
            pending <= next_pending;            // [R03] [R04] [R05] [R06]
        end
    end

    // Registered outputs; host side sees the flags read-only
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            LOCAL_IRQ      <= 1'b0;
            HOST_PEND_VIEW <= `MBXIRQ_PEND_RESET;
        end else if (CLK_EN) begin
            LOCAL_IRQ      <= next_irq;         // [R02]
            HOST_PEND_VIEW <= next_pending;     // [R07]
        end
    end

    // Read data; unmapped words read zero. Reflects flags in the data phase.
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            HRDATA <= `MBXIRQ_RDATA_RESET;
        end else if (CLK_EN) begin
            HRDATA <= `MBXIRQ_RDATA_RESET;
            if (addr_hit && !HWRITE) begin
                HRDATA[`MBXIRQ_PEND_MSB:`MBXIRQ_PEND_LSB] <= pending;     // [R07]
                HRDATA[`MBXIRQ_EN0_BIT]                   <= irq_enable[0];
                HRDATA[`MBXIRQ_EN1_BIT]                   <= irq_enable[1];
            end
        end
    end

    // Host write to mailbox 0 with its enable set raises the interrupt next cycle
    a_irq_on_write: assert property (@(posedge CLK) disable iff (!RESET_N)
        CLK_EN && HOST_MBOX_WR[0] && irq_enable[0] && !wr_pend |=> LOCAL_IRQ)  // [R02]
        else $error("mailbox 0 write did not raise interrupt");
    // No interrupt while both enables are clear
    a_irq_disabled: assert property (@(posedge CLK) disable iff (!RESET_N)
        $past(irq_enable) == 2'h0 && $past(CLK_EN) |-> !LOCAL_IRQ)  // [R01] [R08]
        else $error("interrupt raised while disabled");
    // Host write sets the flag
    a_pend_set: assert property (@(posedge CLK) disable iff (!RESET_N)
        CLK_EN && HOST_MBOX_WR[3] |=> pending[3])  // [R03] [R09]
        else $error("mailbox 3 flag not set");
    a_pend_set2: assert property (@(posedge CLK) disable iff (!RESET_N)
        CLK_EN && HOST_MBOX_WR[2] |=> pending[2])  // [R04]
        else $error("mailbox 2 flag not set");
    a_pend_set1: assert property (@(posedge CLK) disable iff (!RESET_N)
        CLK_EN && HOST_MBOX_WR[1] |=> pending[1])  // [R05]
        else $error("mailbox 1 flag not set");
    // Write one clears when no new host write
    a_pend_clear: assert property (@(posedge CLK) disable iff (!RESET_N)
        CLK_EN && wr_pend && HWDATA[0] && !HOST_MBOX_WR[0] |=> !pending[0])  // [R06] [R09]
        else $error("mailbox 0 flag not cleared");
    // Host view tracks flags
    a_host_view: assert property (@(posedge CLK) disable iff (!RESET_N)
        $past(CLK_EN) |-> HOST_PEND_VIEW == pending)  // [R07]
        else $error("host view differs from flags");
    // Enable write lands
    a_en_write: assert property (@(posedge CLK) disable iff (!RESET_N)
        CLK_EN && wr_pend |=> irq_enable[1] == $past(HWDATA[5]))  // [R08]
        else $error("mailbox 1 enable not written");

    // Read address phase to the control word
    sequence s_read_addr;
        CLK_EN && HSEL && HTRANS[1] && HREADY && !HWRITE && (HADDR[11:2] == CTRL_OFF[11:2]);
    endsequence
    // Write address phase to the control word
    sequence s_write_addr;
        CLK_EN && HSEL && HTRANS[1] && HREADY && HWRITE && (HADDR[11:2] == CTRL_OFF[11:2]);
    endsequence
    // Data phase asking to clear mailbox 0 with no competing host write
    sequence s_clear0;
        CLK_EN && HWDATA[0] && !HOST_MBOX_WR[0];
    endsequence

    // Host write sets mailbox 0 flag
    a_pend_set0: assert property (@(posedge CLK) disable iff (!RESET_N)  // [R06] [R09]
        CLK_EN && HOST_MBOX_WR[0] |=> pending[0])
        else $error("mailbox 0 flag not set");
    // Write one clears mailbox 1 flag
    a_pend_clear1: assert property (@(posedge CLK) disable iff (!RESET_N)  // [R05] [R09]
        CLK_EN && wr_pend && HWDATA[1] && !HOST_MBOX_WR[1] |=> !pending[1])
        else $error("mailbox 1 flag not cleared");
    // Write one clears mailbox 2 flag
    a_pend_clear2: assert property (@(posedge CLK) disable iff (!RESET_N)  // [R04] [R09]
        CLK_EN && wr_pend && HWDATA[2] && !HOST_MBOX_WR[2] |=> !pending[2])
        else $error("mailbox 2 flag not cleared");
    // Write one clears mailbox 3 flag
    a_pend_clear3: assert property (@(posedge CLK) disable iff (!RESET_N)  // [R03] [R09]
        CLK_EN && wr_pend && HWDATA[3] && !HOST_MBOX_WR[3] |=> !pending[3])
        else $error("mailbox 3 flag not cleared");
    // Whole clear walk from the address phase on
    a_clear_walk: assert property (@(posedge CLK) disable iff (!RESET_N)  // [R07] [R09]
        s_write_addr ##1 s_clear0 |=> !pending[0])
        else $error("clear walk left mailbox 0 flag set");
    // Flags hold without a write or a strobe
    a_pend_hold: assert property (@(posedge CLK) disable iff (!RESET_N)  // [R09]
        CLK_EN && !wr_pend && HOST_MBOX_WR == 4'h0 |=> $stable(pending))
        else $error("flags changed with no event");

    // Set wins over a same-cycle clear, mailbox 0
    a_set_wins0: assert property (@(posedge CLK) disable iff (!RESET_N)  // [R09]
        CLK_EN && wr_pend && HWDATA[0] && HOST_MBOX_WR[0] |=> pending[0])
        else $error("mailbox 0 set lost to clear");
    // Set wins over a same-cycle clear, mailbox 1
    a_set_wins1: assert property (@(posedge CLK) disable iff (!RESET_N)  // [R09]
        CLK_EN && wr_pend && HWDATA[1] && HOST_MBOX_WR[1] |=> pending[1])
        else $error("mailbox 1 set lost to clear");
    // Set wins over a same-cycle clear, mailbox 2
    a_set_wins2: assert property (@(posedge CLK) disable iff (!RESET_N)  // [R09]
        CLK_EN && wr_pend && HWDATA[2] && HOST_MBOX_WR[2] |=> pending[2])
        else $error("mailbox 2 set lost to clear");
    // Set wins over a same-cycle clear, mailbox 3
    a_set_wins3: assert property (@(posedge CLK) disable iff (!RESET_N)  // [R09]
        CLK_EN && wr_pend && HWDATA[3] && HOST_MBOX_WR[3] |=> pending[3])
        else $error("mailbox 3 set lost to clear");

    // Host view follows every strobe taken with clock enable high one edge later
    a_view_strobe: assert property (@(posedge CLK) disable iff (!RESET_N)  // [R07] [R09]
        CLK_EN && HOST_MBOX_WR != 4'h0 |=> (HOST_PEND_VIEW & $past(HOST_MBOX_WR)) == $past(HOST_MBOX_WR))
        else $error("host view missed a strobe");
    // Mailbox 0 enable write lands
    a_en0_write: assert property (@(posedge CLK) disable iff (!RESET_N)  // [R01]
        CLK_EN && wr_pend |=> irq_enable[0] == $past(HWDATA[4]))
        else $error("mailbox 0 enable not written");
    // Enables hold without a control write
    a_en_hold: assert property (@(posedge CLK) disable iff (!RESET_N)  // [R01] [R08]
        CLK_EN && !wr_pend |=> $stable(irq_enable))
        else $error("enables changed with no write");

    // Mailbox 1 write with its enable raises the interrupt
    a_irq_mbox1: assert property (@(posedge CLK) disable iff (!RESET_N)  // [R02] [R08]
        CLK_EN && HOST_MBOX_WR[1] && irq_enable[1] && !wr_pend |=> LOCAL_IRQ)
        else $error("mailbox 1 write did not raise interrupt");
    // Interrupt only stands for an enabled pending flag
    a_irq_cause: assert property (@(posedge CLK) disable iff (!RESET_N)  // [R02] [R09]
        LOCAL_IRQ && $past(CLK_EN) |-> (pending[1:0] & $past(irq_enable)) != 2'h0)
        else $error("interrupt with no enabled flag");
    // Mailboxes 2 and 3 alone never raise the line
    a_irq_quiet: assert property (@(posedge CLK) disable iff (!RESET_N)  // [R09]
        CLK_EN && pending[1:0] == 2'h0 && HOST_MBOX_WR[1:0] == 2'h0 |=> !LOCAL_IRQ)
        else $error("interrupt from mailbox 2 or 3");
    // Interrupt stays up until the local side writes
    a_irq_stays: assert property (@(posedge CLK) disable iff (!RESET_N)  // [R02]
        CLK_EN && LOCAL_IRQ && !wr_pend |=> LOCAL_IRQ)
        else $error("interrupt dropped without a clear");

    // Clock enable low freezes the flags
    a_freeze_pend: assert property (@(posedge CLK) disable iff (!RESET_N)
        !CLK_EN |=> $stable(pending))
        else $error("flags moved while frozen");
    // Clock enable low freezes the enables
    a_freeze_en: assert property (@(posedge CLK) disable iff (!RESET_N)
        !CLK_EN |=> $stable(irq_enable))
        else $error("enables moved while frozen");
    // Clock enable low freezes the interrupt
    a_freeze_irq: assert property (@(posedge CLK) disable iff (!RESET_N)
        !CLK_EN |=> $stable(LOCAL_IRQ))
        else $error("interrupt moved while frozen");
    // Clock enable low freezes the host view
    a_freeze_view: assert property (@(posedge CLK) disable iff (!RESET_N)
        !CLK_EN |=> $stable(HOST_PEND_VIEW))
        else $error("host view moved while frozen");
    // Clock enable low freezes the read data
    a_freeze_rdata: assert property (@(posedge CLK) disable iff (!RESET_N)
        !CLK_EN |=> $stable(HRDATA))
        else $error("read data moved while frozen");

    // Slave never stalls the bus
    a_hready_high: assert property (@(posedge CLK) disable iff (!RESET_N)
        HREADYOUT)
        else $error("slave inserted a wait state");
    // Slave always answers OKAY
    a_hresp_okay: assert property (@(posedge CLK) disable iff (!RESET_N)
        !HRESP)
        else $error("slave answered with an error");
    // Read returns flags and enables in the data phase
    a_read_data: assert property (@(posedge CLK) disable iff (!RESET_N)  // [R07]
        s_read_addr |=> HRDATA[5:0] == {$past(irq_enable), $past(pending)})
        else $error("read data differs from state");
    // Upper read bits are always zero
    a_rdata_upper: assert property (@(posedge CLK) disable iff (!RESET_N)
        HRDATA[31:6] == 26'h0)
        else $error("upper read bits not zero");
    // Unmapped words read zero
    a_unmapped_zero: assert property (@(posedge CLK) disable iff (!RESET_N)
        CLK_EN && HSEL && HTRANS[1] && HREADY && HADDR[11:2] != CTRL_OFF[11:2] |=> HRDATA == 32'h0000_0000)
        else $error("unmapped word read nonzero");
    // Writes and idle cycles leave no read data
    a_rdata_idle: assert property (@(posedge CLK) disable iff (!RESET_N)
        CLK_EN && (HWRITE || !HTRANS[1]) |=> HRDATA == 32'h0000_0000)
        else $error("read data outside a read");

    // Reset clears the flags
    a_reset_pend: assert property (@(posedge CLK)  // [R03] [R04] [R05] [R06]
        !RESET_N |=> pending == 4'h0)
        else $error("flags not cleared by reset");
    // Reset clears the enables
    a_reset_en: assert property (@(posedge CLK)  // [R01] [R08]
        !RESET_N |=> irq_enable == 2'h0)
        else $error("enables not cleared by reset");
    // Reset drops the interrupt
    a_reset_irq: assert property (@(posedge CLK)  // [R01]
        !RESET_N |=> !LOCAL_IRQ)
        else $error("interrupt not cleared by reset");
    // Reset clears the host view
    a_reset_view: assert property (@(posedge CLK)  // [R07]
        !RESET_N |=> HOST_PEND_VIEW == 4'h0)
        else $error("host view not cleared by reset");
    // Reset clears the read data
    a_reset_rdata: assert property (@(posedge CLK)
        !RESET_N |=> HRDATA == 32'h0000_0000)
        else $error("read data not cleared by reset");
endmodule

// ==== mbxirq_host.sv ====
// Host model: turns a request mask into one-cycle mailbox write strobes.
// Assumes the bench raises each request for one cycle, synchronous to CLK.
`timescale 1ns/100ps
module mbxirq_host (
    input  wire logic       clk,
    input  wire logic [3:0] go,
    output logic      [3:0] strobe
);
    // Registered: each strobe repeats go one cycle later, so it is a one-cycle pulse only when go is
    always_ff @(posedge clk) begin
        strobe <= go;
    end
endmodule

// ==== mailbox_interrupt_flags_test.sv ====
// Self-checking bench for the mailbox interrupt enables and pending flags.
// Assumes a zero-wait AHB-Lite slave and the host strobe model beside it.
`timescale 1ns/100ps
module mailbox_interrupt_flags_test;
    logic        clk = 0, rst_n = 0, hsel = 0, hwrite = 0, hready, hresp, irq;
    logic [11:0] haddr = 12'h000;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] hwdata = 32'h0000_0000, hrdata, q;
    logic [3:0]  go = 4'h0, strobe, view;
    logic        clk_en = 1'b1;
    int          mismatches = 0, checks = 0;
    // Rows: strobe mask, enables, expected pending, expected interrupt
    logic [10:0] rows [6] = '{11'h082, 11'h0A3, 11'h145, 11'h124, 11'h678, 11'h7FF};
    // Clock, 20 ns period
    always #10 clk = ~clk;
    mbxirq_host host (.clk(clk), .go(go), .strobe(strobe));
    mbxirq_top dut (.CLK(clk), .RESET_N(rst_n), .CLK_EN(clk_en), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready),
        .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp), .HOST_MBOX_WR(strobe),
        .HOST_PEND_VIEW(view), .LOCAL_IRQ(irq));
    // One single AHB transfer; read data taken at the data-phase edge
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        q = hrdata;
    endtask
    // Let registered outputs land before looking
    task automatic settle;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Watchdog: the whole run needs well under a thousand cycles
    initial begin
        #100000;
        mismatches++;
        summarize();
    end
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            bus(1'b1, 12'h000, {26'h0, rows[i][6:5], 4'hF});
            @(posedge clk) go <= rows[i][10:7];
            @(posedge clk) go <= 4'h0;
            settle();
            chk("view", 32'(rows[i][4:1]), 32'(view));
            chk("irq", 32'(rows[i][0]), 32'(irq));
            bus(1'b0, 12'h000, 32'h0000_0000);
            chk("ctrl", {26'h0, rows[i][6:5], rows[i][4:1]}, q);
        end
        // Write-one clears a single flag; the other enabled one keeps the line up
        bus(1'b1, 12'h000, 32'h0000_0031);
        settle();
        chk("irq one left", 32'h0000_0001, 32'(irq));
        bus(1'b1, 12'h000, 32'h0000_0032);
        settle();
        chk("view cleared", 32'h0000_000C, 32'(view));
        chk("irq cleared", 32'h0000_0000, 32'(irq));
        // Unmapped word: reads zero, write has no effect
        bus(1'b1, 12'h004, 32'h0000_000F);
        chk("unmapped", 32'h0000_0000, q);
        bus(1'b0, 12'h004, 32'h0000_0000);
        chk("unmapped read", 32'h0000_0000, q);
        bus(1'b0, 12'h000, 32'h0000_0000);
        chk("ctrl kept", 32'h0000_003C, q);
        // Clock enable low: a host strobe is ignored
        @(posedge clk) clk_en <= 1'b0;
        go <= 4'h1;
        @(posedge clk) go <= 4'h0;
        settle();
        chk("frozen view", 32'h0000_000C, 32'(view));
        @(posedge clk) clk_en <= 1'b1;
        // Reset in mid-run clears enables and pending flags
        @(posedge clk) rst_n <= 1'b0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk("view reset", 32'h0000_0000, 32'(view));
        chk("irq reset", 32'h0000_0000, 32'(irq));
        bus(1'b0, 12'h000, 32'h0000_0000);
        chk("ctrl reset", 32'h0000_0000, q);
        chk("hresp", 32'h0000_0000, 32'(hresp));
        summarize();
    end
endmodule
